// >>> src/dhbc_pkg.sv
// Constants and types shared by the bridge chopper device and its controller.
// Assumes a single 250 MHz system clock on both ends.
package dhbc_pkg;
   localparam int CLK_MHZ       = 250;        // System clock rate
   localparam int BLANK_NS      = 2800;       // sense_blank_time
   localparam int BLANK_CYC     = (BLANK_NS * CLK_MHZ + 999) / 1000;
   localparam int BRAKE_MS      = 10;         // Brake time before switch-off
   localparam int BRAKE_CYC     = BRAKE_MS * 1000 * CLK_MHZ;
   localparam int WAKE_US       = 1000;       // Recovery after sleep
   localparam int WAKE_CYC      = WAKE_US * CLK_MHZ;
   localparam int PWM_US        = 40;         // Fixed PWM period
   localparam int PWM_CYC       = PWM_US * CLK_MHZ;
   localparam int OCP_NS        = 2000;       // Over-current persistence time
   localparam int OCP_CYC       = OCP_NS * CLK_MHZ / 1000;
   localparam int SENSE_W       = 10;         // Shunt and reference word width
   localparam int GAIN          = 5;          // Shunt amplifier gain
   localparam int PCT_FULL      = 100;        // Scale 00
   localparam int PCT_71        = 71;         // Scale 01
   localparam int PCT_38        = 38;         // Scale 10
   localparam int MIX_DIV       = 3;          // Fast part of mixed decay
   localparam int CLEAR_CYC     = 8;          // Logic clear pulse length
   // Controller register map
   localparam int ADDR_W        = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;   // Pin settings
   localparam logic [7:0] REG_CMD  = 8'h04;   // Commands
   localparam logic [7:0] REG_STAT = 8'h08;   // Status
   localparam logic [31:0] CTRL_RST = 32'h00000400; // Sleep requested
   localparam int F_EN          = 0;          // Enables, 2 bits
   localparam int F_DIR         = 2;          // Directions, 2 bits
   localparam int F_SHI         = 4;          // Scale high bits, 2 bits
   localparam int F_SLO         = 6;          // Scale low bits, 2 bits
   localparam int F_DECAY       = 8;          // Decay mode, 2 bits
   localparam int F_SLEEP       = 10;         // Sleep request
   localparam int F_CLEAR       = 0;          // Command: pulse logic clear
   localparam int S_FAULT       = 0;          // Status: fault flag low
   localparam int S_READY       = 1;          // Status: wake time elapsed
   localparam int S_CLEAR       = 2;          // Status: clear pulse running
   typedef enum logic [1:0] {
      DHBC_SLOW, DHBC_FAST, DHBC_MIXED
   } dhbc_decay_type;
   typedef enum logic [1:0] {
      DHBC_OFF, DHBC_DRIVE, DHBC_DECAY, DHBC_BRAKE
   } dhbc_bstate_type;
endpackage

// >>> src/dhbc_link_if.sv
// Parallel pin link between stepper controller and bridge device.
// The open-drain fault flag is resolved here; the three-state decay pin passes as level and enable.
`timescale 1ns/10ps
interface dhbc_link_if;
   logic [1:0] bridge_enable_in;        // Per-bridge enable
   logic [1:0] current_direction_in;    // Per-bridge direction
   logic [1:0] scale_select_hi;         // Scale select, upper bit
   logic [1:0] scale_select_lo;         // Scale select, lower bit
   logic       decay_mode_o;            // Decay pin level when driven
   logic       decay_mode_oe_n;         // Low while decay pin is driven
   logic       logic_clear_n;           // Active-low logic reset
   logic       low_power_request_n;     // Active-low sleep
   logic       shutdown_flag_o;         // Fault flag drive level
   logic       shutdown_flag_oe_n;      // Low while flag pulled down
   logic       shutdown_flag_n;         // Resolved flag with pull-up
   // Pull-up on the open-drain flag
   assign shutdown_flag_n = shutdown_flag_oe_n ? 1'b1 : shutdown_flag_o;
   modport dev (
      input  bridge_enable_in, current_direction_in, scale_select_hi,
      input  scale_select_lo, decay_mode_o, decay_mode_oe_n,
      input  logic_clear_n, low_power_request_n,
      output shutdown_flag_o, shutdown_flag_oe_n
   );
   modport ctl (
      output bridge_enable_in, current_direction_in, scale_select_hi,
      output scale_select_lo, decay_mode_o, decay_mode_oe_n,
      output logic_clear_n, low_power_request_n,
      input  shutdown_flag_n
   );
endinterface

// >>> src/dhbc_ctl.sv
// Stepper controller end: software registers drive the parallel pins.
// Assumes a one-cycle read/write strobe port and the link interface.
`timescale 1ns/10ps
module dhbc_ctl #(
   parameter int WAKE_CYCLES = dhbc_pkg::WAKE_CYC
) (
   input  wire logic                       CLK_SYS,
   input  wire logic                       SRST,
   dhbc_link_if.ctl                        LINK,
   input  wire logic [dhbc_pkg::ADDR_W-1:0] ADDR,
   input  wire logic [31:0]                WDATA,
   input  wire logic                       WR,
   input  wire logic                       RD,
   output logic [31:0]                     RDATA
);
   import dhbc_pkg::*;
   localparam int WW = $clog2(WAKE_CYCLES + 1);
   logic [31:0]   ctrl_q;           // Pin settings register
   logic [3:0]    clr_q;            // Clear pulse counter
   logic [WW-1:0] wake_q;           // Wake wait counter
   logic          fault_q;          // Sampled fault flag
   logic [1:0]    dmode;            // Decay mode field

   assign dmode = ctrl_q[F_DECAY +: 2];

   // Settings register write
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         ctrl_q <= CTRL_RST;
      end else if (WR && ADDR == REG_CTRL) begin
         ctrl_q <= WDATA;
      end
   end

   // Logic clear pulse; pulsing it clears a latched shutdown
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         clr_q <= 4'h0;
      end else if (WR && ADDR == REG_CMD && WDATA[F_CLEAR]) begin
         clr_q <= 4'(CLEAR_CYC);
      end else if (clr_q != 4'h0) begin
         clr_q <= clr_q - 4'h1;
      end
   end

   // Wait out the device recovery after sleep ends
   always_ff @(posedge CLK_SYS) begin
      if (SRST || ctrl_q[F_SLEEP]) begin
         wake_q <= WW'(WAKE_CYCLES);
      end else if (wake_q != '0) begin
         wake_q <= wake_q - WW'(1);
      end
   end

   // Fault flag sample
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         fault_q <= 1'b0;
      end else begin
         fault_q <= !LINK.shutdown_flag_n;
      end
   end

   // Pin drivers; enables held low until recovered
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         LINK.bridge_enable_in     <= 2'h0;
         LINK.current_direction_in <= 2'h0;
         LINK.scale_select_hi      <= 2'h0;
         LINK.scale_select_lo      <= 2'h0;
         LINK.decay_mode_o         <= 1'b0;
         LINK.decay_mode_oe_n      <= 1'b0;
         LINK.logic_clear_n        <= 1'b0;
         LINK.low_power_request_n  <= 1'b0;
      end else begin
         LINK.bridge_enable_in     <= (wake_q == '0) ?
                                      ctrl_q[F_EN +: 2] : 2'h0;
         LINK.current_direction_in <= ctrl_q[F_DIR +: 2];
         LINK.scale_select_hi      <= ctrl_q[F_SHI +: 2];
         LINK.scale_select_lo      <= ctrl_q[F_SLO +: 2];
         // High selects fast, low slow, open mixed
         LINK.decay_mode_o         <= (dmode == DHBC_FAST);
         LINK.decay_mode_oe_n      <= (dmode == DHBC_MIXED);
         LINK.logic_clear_n        <= (clr_q == 4'h0);
         LINK.low_power_request_n  <= !ctrl_q[F_SLEEP];
      end
   end

   // Read data, one cycle after the strobe; unmapped reads zero
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         RDATA <= 32'h0;
      end else if (RD) begin
         case (ADDR)
            REG_CTRL: RDATA <= ctrl_q;
            REG_STAT: RDATA <= {29'h0, clr_q != 4'h0, wake_q == '0,
                                fault_q};
            default:  RDATA <= 32'h0;
         endcase
      end else begin
         RDATA <= 32'h0;
      end
   end
endmodule

// >>> src/dhbc_dev.sv
// Device end: two H-bridge chopping controllers with braking and shutdown.
// Assumes digitised shunt and reference words and synchronous pin inputs.
// What this block does
// - Enable low floats outputs; direction sets polarity.
// - Shunt reading times five compared with threshold.
// - Scale 00/01/10 gives 100/71/38 percent.
// - Scale 11 disables the bridge.
// - Threshold ends pulse; decay until next cycle.
// - Fast decay inverts every bridge switch.
// - Fast decay stops all switches near zero.
// - Decay pin high selects fast decay.
// - Slow decay: high sides off, lows on.
// - Decay pin low selects slow decay.
// - Floating pin: fast first third, then slow.
// - Enable falling brakes ten ms, then off.
// - Logic clear resets logic, ignores inputs.
// - Sleep stops bridges, pump, regulator, inputs.
// - Clear or sleep brakes ten ms, then off.
// - Wait about one ms after sleep ends.
// - Over-current switch loses gate drive on the next clock.
// - Lasting over-current brakes, disables, flags fault.
// - Over-current shutdown latched until clear or power.
// - Over-temperature brakes, stops, flags, auto-resumes.
// - Supply low resets logic until supply recovers.
// - Ignore comparator during blanking time per pulse.
// - Pulses start at fixed PWM frequency.
`timescale 1ns/10ps
module dhbc_dev #(
   parameter int BRAKE_CYCLES = dhbc_pkg::BRAKE_CYC,
   parameter int WAKE_CYCLES  = dhbc_pkg::WAKE_CYC,
   parameter int PWM_CYCLES   = dhbc_pkg::PWM_CYC
) (
   input  wire logic                         CLK_SYS,
   input  wire logic                         SRST,
   dhbc_link_if.dev                          LINK,
   input  wire logic [2*dhbc_pkg::SENSE_W-1:0] SHUNT_SENSE_PIN,
   input  wire logic [2*dhbc_pkg::SENSE_W-1:0] THRESHOLD_REF_IN,
   input  wire logic [1:0]                   CURRENT_NEAR_ZERO,
   input  wire logic [7:0]                   OVERCURRENT_TRIP,
   input  wire logic                         THERMAL_TRIP,
   input  wire logic                         SUPPLY_LOW_LOCKOUT,
   output logic [1:0]                        BRIDGE_OUT_A,
   output logic [1:0]                        BRIDGE_OUT_A_OE_N,
   output logic [1:0]                        BRIDGE_OUT_B,
   output logic [1:0]                        BRIDGE_OUT_B_OE_N,
   output logic                              AUX_REGULATOR_ON,
   output logic                              CHARGE_PUMP_ON
);
   import dhbc_pkg::*;
   localparam int CW = $clog2(BRAKE_CYCLES + PWM_CYCLES + 1);
   localparam int PW = $clog2(PWM_CYCLES + 1);
   localparam int WW = $clog2(WAKE_CYCLES + 1);
   localparam int OW = $clog2(OCP_CYC + 1);
   localparam int MW = SENSE_W + 10;

   logic              rst_i;        // Reset from port or supply lockout
   logic              run;          // Neither clear nor sleep asserted
   logic [1:0]        en_q;         // Captured enables
   logic [1:0]        en_prev_q;    // Enables one cycle earlier
   logic [1:0]        dir_q;        // Captured directions
   logic [1:0]        shi_q;        // Captured scale high bits
   logic [1:0]        slo_q;        // Captured scale low bits
   dhbc_decay_type    dec_q;        // Captured decay mode
   logic [WW-1:0]     wake_q;       // Sleep recovery counter
   logic [OW-1:0]     ocp_cnt_q;    // Over-current persistence count
   logic              ocp_lat_q;    // Latched over-current shutdown
   logic              stop;         // Clear, sleep, latched over-current or heat
   logic              stop_q;       // Stop one cycle earlier
   logic              stop_rise;    // Start of a shutdown brake
   logic [PW-1:0]     pwm_q;        // PWM period counter
   logic              pwm_start;    // First cycle of a PWM period
   logic [1:0]        braking;      // Bridge currently braking

   // Supply lockout resets all logic
   assign rst_i = SRST || SUPPLY_LOW_LOCKOUT;
   assign run   = LINK.logic_clear_n && LINK.low_power_request_n;

   // Capture logic inputs only while running
   always_ff @(posedge CLK_SYS) begin
      if (rst_i || !LINK.logic_clear_n) begin
         en_q  <= 2'h0;
         dir_q <= 2'h0;
         shi_q <= 2'h0;
         slo_q <= 2'h0;
         dec_q <= DHBC_SLOW;
      end else if (run) begin
         en_q  <= LINK.bridge_enable_in;
         dir_q <= LINK.current_direction_in;
         shi_q <= LINK.scale_select_hi;
         slo_q <= LINK.scale_select_lo;
         // Driven high fast, driven low slow, open mixed
         if (LINK.decay_mode_oe_n) begin
            dec_q <= DHBC_MIXED;
         end else if (LINK.decay_mode_o) begin
            dec_q <= DHBC_FAST;
         end else begin
            dec_q <= DHBC_SLOW;
         end
      end
   end

   // Previous enables, for falling-edge detection
   always_ff @(posedge CLK_SYS) begin
      if (rst_i) begin
         en_prev_q <= 2'h0;
      end else begin
         en_prev_q <= en_q;
      end
   end

   // Recovery time after sleep is released
   always_ff @(posedge CLK_SYS) begin
      if (rst_i || !LINK.low_power_request_n) begin
         wake_q <= WW'(WAKE_CYCLES);
      end else if (wake_q != '0) begin
         wake_q <= wake_q - WW'(1);
      end
   end

   // Over-current persistence and latch; clear pulse releases it
   always_ff @(posedge CLK_SYS) begin
      if (rst_i || !LINK.logic_clear_n) begin
         ocp_cnt_q <= '0;
         ocp_lat_q <= 1'b0;
      end else if (|OVERCURRENT_TRIP) begin
         if (ocp_cnt_q == OW'(OCP_CYC)) begin
            ocp_lat_q <= 1'b1;
         end else begin
            ocp_cnt_q <= ocp_cnt_q + OW'(1);
         end
      end else begin
         ocp_cnt_q <= '0;
      end
   end

   // Stop sources: clear, sleep, over-current, heat
   assign stop      = !run || ocp_lat_q || THERMAL_TRIP;
   assign stop_rise = stop && !stop_q;

   // Stop history and fault flag drive
   always_ff @(posedge CLK_SYS) begin
      if (rst_i) begin
         stop_q                  <= 1'b0;
         LINK.shutdown_flag_o    <= 1'b0;
         LINK.shutdown_flag_oe_n <= 1'b1;
      end else begin
         stop_q                  <= stop;
         LINK.shutdown_flag_o    <= 1'b0;
         // Flag low while latched or hot
         LINK.shutdown_flag_oe_n <= !(ocp_lat_q || THERMAL_TRIP);
      end
   end

   // PWM period, held at zero in stop, independent of chop events
   always_ff @(posedge CLK_SYS) begin
      if (rst_i || stop || pwm_q == PW'(PWM_CYCLES - 1)) begin
         pwm_q <= '0;
      end else begin
         pwm_q <= pwm_q + PW'(1);
      end
   end
   assign pwm_start = !stop && pwm_q == '0;

   // Regulator off in sleep; pump kept while braking
   always_ff @(posedge CLK_SYS) begin
      if (rst_i) begin
         AUX_REGULATOR_ON <= 1'b0;
         CHARGE_PUMP_ON   <= 1'b0;
      end else begin
         AUX_REGULATOR_ON <= LINK.low_power_request_n;
         CHARGE_PUMP_ON   <= LINK.low_power_request_n || |braking;
      end
   end

   // One chopping controller per bridge
   for (genvar b = 0; b < 2; b++) begin : g_br
      dhbc_bstate_type        st_q;     // Bridge state
      logic [CW-1:0]          cnt_q;    // Blank, off or brake time
      logic [PW-1:0]          mix_q;    // Fast part of mixed decay
      logic                   zs_q;     // Fast decay stopped near zero
      dhbc_decay_type         mode_q;   // Decay mode of this off time
      logic [6:0]             pct;      // Threshold percentage
      logic [MW-1:0]          amp;      // Amplified shunt reading
      logic [MW-1:0]          lim;      // Scaled reference
      logic                   trip;     // Current reached threshold
      logic                   halt;     // Bridge may not drive
      logic                   fast_now; // Fast decay applies now
      logic [3:0]             drv;      // Gates {hs_a, ls_a, hs_b, ls_b}
      logic [3:0]             gate;     // Gates before protection
      logic [3:0]             gate_q;   // Gates after protection

      // Scale select to threshold percentage
      always_comb begin
         case ({shi_q[b], slo_q[b]})
            2'b00:   pct = 7'(PCT_FULL);
            2'b01:   pct = 7'(PCT_71);
            2'b10:   pct = 7'(PCT_38);
            default: pct = 7'h00;
         endcase
      end

      // Gain of five against percent of reference
      assign amp  = MW'(SHUNT_SENSE_PIN[b*SENSE_W +: SENSE_W])
                    * MW'(GAIN * PCT_FULL);
      assign lim  = MW'(THRESHOLD_REF_IN[b*SENSE_W +: SENSE_W]) * MW'(pct);
      assign trip = amp >= lim;
      // Scale 11 disables the bridge
      assign halt = !en_q[b] || (shi_q[b] && slo_q[b]) || stop ||
                    wake_q != '0;
      assign braking[b] = st_q == DHBC_BRAKE;

      // Bridge sequencing
      always_ff @(posedge CLK_SYS) begin
         if (rst_i) begin
            st_q   <= DHBC_OFF;
            cnt_q  <= '0;
            mix_q  <= '0;
            zs_q   <= 1'b0;
            mode_q <= DHBC_SLOW;
         end else if (stop_rise || (en_prev_q[b] && !en_q[b])) begin
            st_q  <= DHBC_BRAKE;
            cnt_q <= '0;
         end else begin
            case (st_q)
               DHBC_BRAKE: begin
                  // Brake timed by counter, then all off
                  if (cnt_q == CW'(BRAKE_CYCLES - 1)) begin
                     st_q <= DHBC_OFF;
                  end else begin
                     cnt_q <= cnt_q + CW'(1);
                  end
               end
               DHBC_DRIVE: begin
                  if (halt) begin
                     st_q <= DHBC_OFF;
                  end else if (cnt_q >= CW'(BLANK_CYC) && trip) begin
                     // Pulse ends at threshold after blanking
                     st_q   <= DHBC_DECAY;
                     cnt_q  <= '0;
                     zs_q   <= 1'b0;
                     mode_q <= dec_q;
                     mix_q  <= PW'((PWM_CYCLES - 1 - int'(pwm_q)) / MIX_DIV);
                  end else if (pwm_start) begin
                     cnt_q <= '0;
                  end else if (cnt_q < CW'(BLANK_CYC)) begin
                     cnt_q <= cnt_q + CW'(1);
                  end
               end
               DHBC_DECAY: begin
                  if (halt) begin
                     st_q <= DHBC_OFF;
                  end else if (pwm_start) begin
                     st_q  <= DHBC_DRIVE;
                     cnt_q <= '0;
                  end else begin
                     cnt_q <= cnt_q + CW'(1);
                     if (fast_now && CURRENT_NEAR_ZERO[b]) begin
                        zs_q <= 1'b1;
                     end
                  end
               end
               default: begin
                  if (pwm_start && !halt) begin
                     st_q  <= DHBC_DRIVE;
                     cnt_q <= '0;
                  end
               end
            endcase
         end
      end

      // Fast always, or mixed within its first third
      assign fast_now = mode_q == DHBC_FAST ||
                        (mode_q == DHBC_MIXED &&
                         cnt_q < CW'(mix_q));
      // Direction 1 drives A high and B low
      assign drv = dir_q[b] ? 4'b1001 : 4'b0110;

      // Switch states per bridge state
      always_comb begin
         case (st_q)
            DHBC_DRIVE: gate = drv;
            DHBC_BRAKE: gate = 4'b0101;
            DHBC_DECAY: begin
               if (fast_now) begin
                  gate = zs_q ? 4'h0 : ~drv;
               end else begin
                  gate = 4'b0101;
               end
            end
            default:    gate = 4'h0;
         endcase
      end

      // Over-current switch loses its gate drive
      always_ff @(posedge CLK_SYS) begin
         if (rst_i) begin
            gate_q <= 4'h0;
         end else begin
            gate_q <= gate & ~OVERCURRENT_TRIP[b*4 +: 4];
         end
      end

      // Output pins float when neither switch conducts
      assign BRIDGE_OUT_A[b]      = gate_q[3];
      assign BRIDGE_OUT_A_OE_N[b] = !(gate_q[3] || gate_q[2]);
      assign BRIDGE_OUT_B[b]      = gate_q[1];
      assign BRIDGE_OUT_B_OE_N[b] = !(gate_q[1] || gate_q[0]);
   end
endmodule

// >>> test/dhbc_chk.sv
// Checker on the bridge link pins and the bridge gate outputs.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module dhbc_chk (
   input wire logic       CLK_SYS,
   input wire logic       SRST,
   input wire logic [1:0] bridge_enable_in,
   input wire logic [1:0] scale_select_hi,
   input wire logic [1:0] scale_select_lo,
   input wire logic       logic_clear_n,
   input wire logic       low_power_request_n,
   input wire logic       shutdown_flag_n,
   input wire logic [1:0] BRIDGE_OUT_A,
   input wire logic [1:0] BRIDGE_OUT_A_OE_N,
   input wire logic [1:0] BRIDGE_OUT_B,
   input wire logic [1:0] BRIDGE_OUT_B_OE_N,
   input wire logic [7:0] OVERCURRENT_TRIP,
   input wire logic       THERMAL_TRIP,
   input wire logic       AUX_REGULATOR_ON
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (SRST);
   // High-side gates that are really driven
   wire [1:0] hs_a = BRIDGE_OUT_A & ~BRIDGE_OUT_A_OE_N;
   wire [1:0] hs_b = BRIDGE_OUT_B & ~BRIDGE_OUT_B_OE_N;
   // Bridge 0 braking: both low sides on
   wire brk0 = !BRIDGE_OUT_A_OE_N[0] && !BRIDGE_OUT_B_OE_N[0]
               && !BRIDGE_OUT_A[0] && !BRIDGE_OUT_B[0];
   sequence clr_run; !logic_clear_n[*3]; endsequence
   sequence slp_run; !low_power_request_n[*3]; endsequence
   clear_len_a: assert property ($fell(logic_clear_n) |->
      !logic_clear_n[*8] ##1 logic_clear_n) else $error("clear length");
   clear_off_a: assert property (clr_run |-> (hs_a | hs_b) == 2'b00)
      else $error("high side on in clear");
   sleep_off_a: assert property (slp_run |-> !AUX_REGULATOR_ON
      && (hs_a | hs_b) == 2'b00) else $error("active in sleep");
   shoot_thru_a: assert property ((hs_a & hs_b) == 2'b00)
      else $error("both high sides on");
   ocp_mask_a: assert property (OVERCURRENT_TRIP[3] |=> !hs_a[0])
      else $error("gate kept on over-current");
   therm_flag_a: assert property
      (THERMAL_TRIP[*2] |-> !shutdown_flag_n)
      else $error("no flag on thermal");
   // Latch drops one edge into clear, flag one edge later
   flag_clear_a: assert property
      ((!logic_clear_n && !THERMAL_TRIP)[*3] |-> shutdown_flag_n)
      else $error("flag kept in clear");
   wake_hold_a: assert property ($rose(low_power_request_n) |->
      (bridge_enable_in == 2'b00)[*8]) else $error("enable during wake");
   brake_enter_a: assert property ($fell(bridge_enable_in[0])
      && logic_clear_n && low_power_request_n |-> ##3 brk0[*8])
      else $error("no brake after enable fall");
   // Capture, state and gate registers lie between pin and output
   scale_off_a: assert property
      ((scale_select_hi[1] && scale_select_lo[1])[*4] |->
      !hs_a[1] && !hs_b[1]) else $error("bridge on at scale 11");
endmodule

// >>> test/dual_hbridge_chop_control_bench.sv
// Bench joining controller and device; register reads checked via queue.
// Assumes the link interface and short brake, wake and PWM counts.
`timescale 1ns/10ps
module dual_hbridge_chop_control_bench;
   import dhbc_pkg::*;
   logic        clk, srst, wr_s, rd_s, th, rd_q, d, lo;
   logic [7:0]  adr, oct;
   logic [31:0] wd, rdt, ctrl, r;
   logic [19:0] sh, rf;
   logic [1:0]  nz, a, ao, b, bo;
   logic        aux;
   int          failures, compares;
   logic [31:0] expq[$];
   dhbc_link_if u_link();
   dhbc_ctl #(.WAKE_CYCLES(40)) u_dhbc_ctl (.CLK_SYS(clk), .SRST(srst),
      .LINK(u_link.ctl), .ADDR(adr), .WDATA(wd), .WR(wr_s), .RD(rd_s),
      .RDATA(rdt));
   dhbc_dev #(.BRAKE_CYCLES(50), .WAKE_CYCLES(40), .PWM_CYCLES(1000))
   u_dhbc_dev (.CLK_SYS(clk), .SRST(srst), .LINK(u_link.dev),
      .SHUNT_SENSE_PIN(sh), .THRESHOLD_REF_IN(rf), .CURRENT_NEAR_ZERO(nz),
      .OVERCURRENT_TRIP(oct), .THERMAL_TRIP(th), .SUPPLY_LOW_LOCKOUT(lo),
      .BRIDGE_OUT_A(a), .BRIDGE_OUT_A_OE_N(ao), .BRIDGE_OUT_B(b),
      .BRIDGE_OUT_B_OE_N(bo), .AUX_REGULATOR_ON(aux), .CHARGE_PUMP_ON());
   dhbc_chk u_dhbc_chk (.CLK_SYS(clk), .SRST(srst),
      .bridge_enable_in(u_link.bridge_enable_in),
      .scale_select_hi(u_link.scale_select_hi),
      .scale_select_lo(u_link.scale_select_lo),
      .logic_clear_n(u_link.logic_clear_n),
      .low_power_request_n(u_link.low_power_request_n),
      .shutdown_flag_n(u_link.shutdown_flag_n), .BRIDGE_OUT_A(a),
      .BRIDGE_OUT_A_OE_N(ao), .BRIDGE_OUT_B(b), .BRIDGE_OUT_B_OE_N(bo),
      .OVERCURRENT_TRIP(oct), .THERMAL_TRIP(th), .AUX_REGULATOR_ON(aux));
   // Prints the verdict and stops
   task automatic end_sim();
      if (failures == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Compares one value and counts it
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
   endtask
   // One-cycle register write
   task automatic wr(logic [7:0] ad, logic [31:0] v);
      @(posedge clk);
      adr <= ad;
      wd <= v;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   // One-cycle register read; expected value queued for the monitor
   task automatic rd(logic [7:0] ad, logic [31:0] e);
      @(posedge clk);
      adr <= ad;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      expq.push_back(e);
   endtask
   // Bridge 0 pins {A, B, A_OE_N, B_OE_N}, sampled settled
   task automatic pins(logic [3:0] e);
      @(negedge clk);
      chk("bridge0", 32'(e), 32'({a[0], b[0], ao[0], bo[0]}));
   endtask
   function automatic logic drv();
      return {a[0], b[0], ao[0], bo[0]} === {d, ~d, 2'b00};
   endfunction
   // Waits for the start of a fresh drive pulse on bridge 0
   task automatic wdrv();
      int i;
      for (i = 0; i < 1200 && drv(); i++)
         @(negedge clk);
      for (i = i; i < 2400 && !drv(); i++)
         @(negedge clk);
      if (i >= 2400) begin
         failures++;
         end_sim();
      end
   endtask
   // Read data stand one cycle after the strobe
   always @(posedge clk) begin
      rd_q <= rd_s;
      if (rd_q)
         chk("rdata", expq.pop_front(), rdt);
   end
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      {srst, wr_s, rd_s, th, lo, adr, oct, wd, nz} = '0;
      srst = 1'b1;
      failures = 0;
      compares = 0;
      r = $urandom(32'hb153);
      d = 1'($urandom);
      rf = {10'h200, 1'b1, 9'($urandom)};
      sh = {10'h000, 10'h3ff};
      ctrl = 32'h000000a3 | (32'(d) << F_DIR);
      cyc(8);
      srst <= 1'b0;
      rd(REG_CTRL, CTRL_RST);
      rd(REG_STAT, 32'h0);
      rd(8'h10, 32'h0);
      wr(REG_CTRL, ctrl);
      cyc(60);
      rd(REG_STAT, 32'h2);
      wdrv();
      pins({d, ~d, 2'b00});
      chk("bridge1", 32'({ao[1], bo[1]}), 32'h3);
      cyc(600);
      pins({d, ~d, 2'b00});
      cyc(120);
      pins(4'b0000);
      wr(REG_CTRL, ctrl | 32'h100);
      wdrv();
      cyc(720);
      pins({~d, d, 2'b00});
      cyc(1);
      nz <= 2'b01;
      cyc(3);
      pins(4'b0011);
      cyc(1);
      nz <= 2'b00;
      wr(REG_CTRL, ctrl | 32'h200);
      wdrv();
      cyc(720);
      pins({~d, d, 2'b00});
      cyc(180);
      pins(4'b0000);
      wr(REG_CTRL, ctrl & ~32'h3);
      cyc(4);
      @(negedge clk);
      chk("brake1", 32'({a[1], b[1], ao[1], bo[1]}), 32'h0);
      cyc(60);
      pins(4'b0011);
      wr(REG_CTRL, ctrl);
      cyc(10);
      oct <= 8'h08;
      cyc(520);
      oct <= 8'h00;
      cyc(5);
      rd(REG_STAT, 32'h3);
      cyc(100);
      rd(REG_STAT, 32'h3);
      wr(REG_CMD, 32'h1);
      cyc(20);
      rd(REG_STAT, 32'h2);
      // Latch a second shutdown, then let supply lockout reset it
      oct <= 8'h10;
      cyc(520);
      oct <= 8'h00;
      lo <= 1'b1;
      cyc(3);
      rd(REG_STAT, 32'h2);
      lo <= 1'b0;
      th <= 1'b1;
      cyc(5);
      rd(REG_STAT, 32'h3);
      th <= 1'b0;
      cyc(5);
      rd(REG_STAT, 32'h2);
      wr(REG_CTRL, CTRL_RST);
      cyc(5);
      @(negedge clk);
      chk("aux", 32'(aux), 32'h0);
      cyc(3);
      end_sim();
   end
endmodule
